// file: common/dcc_pkg.sv
package dcc_pkg;
   // register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MAX_CH = 8;
   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h40;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h44;
   // channel control field positions
   localparam int BUSY_BIT = 15;
   localparam int CHNS_BIT = 8;
   localparam int EN_BIT = 7;
   localparam int AED_BIT = 6;
   localparam int CHN_BIT = 5;
   localparam int AEN_BIT = 4;
   localparam int EDET_BIT = 2;
   localparam int PRI_LSB = 0;
   localparam int PRI_W = 2;
   // writable positions and reset value of the control word
   localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h0000_01f3;
   localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
   // interrupt status layout
   localparam int IRQ_DONE_LSB = 0;
   localparam int IRQ_ABORT_LSB = 8;
   localparam int IRQ_W = 16;
   localparam logic [IRQ_W-1:0] IRQ_RST = 16'h0000;
   // bus slave states
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } dcc_bus_state_type;
endpackage

// file: common/dcc_reg_if.sv
`timescale 1ns/1ps
interface dcc_reg_if;
   logic [dcc_pkg::ADDR_W-1:0] addr;
   logic wr_stb;
   logic [dcc_pkg::DATA_W-1:0] wdata;
   logic [3:0] be;
   logic [dcc_pkg::DATA_W-1:0] rdata;
   modport slave (
      output addr,
      output wr_stb,
      output wdata,
      output be,
      input rdata
   );
   modport regs (
      input addr,
      input wr_stb,
      input wdata,
      input be,
      output rdata
   );
endinterface

// file: rtl/dcc_avs_slave.sv
`timescale 1ns/1ps
module dcc_avs_slave (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // avalon-mm slave
   input wire logic [dcc_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [dcc_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [dcc_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // register side
   dcc_reg_if.slave reg_bus
);
   import dcc_pkg::*;

   dcc_bus_state_type state_q;
   logic [DATA_W-1:0] rdata_q;
   logic req;

   assign req = avs_read_i | avs_write_i;

   // every access waits exactly one cycle, then completes
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state_q <= BUS_IDLE;
      end else begin
         case (state_q)
            BUS_IDLE: begin
               if (req) begin
                  state_q <= BUS_ACK;
               end
            end
            BUS_ACK: state_q <= BUS_IDLE;
            default: state_q <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_q <= '0;
      end else if (state_q == BUS_IDLE && avs_read_i) begin
         rdata_q <= reg_bus.rdata;
      end
   end

   assign avs_waitrequest_o = req & (state_q != BUS_ACK);
   assign avs_readdata_o = rdata_q;
   assign reg_bus.addr = avs_address_i;
   assign reg_bus.wr_stb = avs_write_i & (state_q == BUS_ACK);
   assign reg_bus.wdata = avs_writedata_i;
   assign reg_bus.be = avs_byteenable_i;
endmodule // dcc_avs_slave

// file: rtl/dcc_dma_ctrl.sv
// Overview of operation
// RULE_01: busy reads one while active or enabled
// RULE_02: chain select picks lower or higher neighbour
// RULE_03: chain select matters only when chaining enabled
// RULE_04: enable bit enables, clearing disables channel
// RULE_05: events while disabled need allow bit
// RULE_06: chain enable permits neighbour completion enabling
// RULE_07: auto enable keeps channel on after block
// RULE_08: event detected flag shows registered event
// RULE_09: two-bit binary priority, three is highest
// RULE_10: disable finishes transaction; poll busy for suspension
// RULE_11: unimplemented control bits read zero, ignore writes
// RULE_12: control fields reset to zero
// RULE_13: event flag set on event, cleared on service
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module dcc_dma_ctrl #(
   parameter int NUM_CH = 4
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // avalon-mm slave
   input wire logic [dcc_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [dcc_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [dcc_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // events from the transfer datapath, one bit per channel
   input wire logic [NUM_CH-1:0] start_event_i,
   input wire logic [NUM_CH-1:0] abort_event_i,
   input wire logic [NUM_CH-1:0] block_done_i,
   input wire logic [NUM_CH-1:0] txn_active_i,
   input wire logic [NUM_CH-1:0] service_start_i,
   // channel control towards the datapath and arbiter
   output logic [NUM_CH-1:0] ch_enable_o,
   output logic [NUM_CH-1:0] ch_busy_o,
   output logic [NUM_CH-1:0] ch_event_pending_o,
   output logic [NUM_CH-1:0] start_req_o,
   output logic [NUM_CH-1:0] abort_req_o,
   output logic [dcc_pkg::PRI_W*NUM_CH-1:0] ch_priority_o,
   // interrupt
   output logic irq_o
);
   import dcc_pkg::*;

   dcc_reg_if reg_bus ();

   dcc_avs_slave u_avs (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .reg_bus(reg_bus.slave)
   );

   // address decode
   logic [2:0] ch_idx;
   logic ctrl_hit;
   logic stat_hit;
   logic mask_hit;
   logic [DATA_W-1:0] be_mask;
   logic [DATA_W-1:0] ctrl_rd [MAX_CH];
   logic [NUM_CH+1:0] done_pad;
   logic [MAX_CH-1:0] done_ev;
   logic [MAX_CH-1:0] abort_ev;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [IRQ_W-1:0] irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_d;
   logic irq_d;
   logic [DATA_W-1:0] stat_word;
   logic [DATA_W-1:0] mask_word;

   assign ch_idx = reg_bus.addr[4:2];
   assign ctrl_hit = (reg_bus.addr[ADDR_W-1:5] == CTRL_BASE[ADDR_W-1:5])
                     && (reg_bus.addr[1:0] == 2'b00)
                     && ({29'h0, ch_idx} < 32'(NUM_CH));
   assign stat_hit = (reg_bus.addr == IRQ_STAT_OFS);
   assign mask_hit = (reg_bus.addr == IRQ_MASK_OFS);
   assign be_mask = {{8{reg_bus.be[3]}}, {8{reg_bus.be[2]}},
                     {8{reg_bus.be[1]}}, {8{reg_bus.be[0]}}};

   // completion of neighbours, padded so the edge channels see no neighbour
   assign done_pad = {1'b0, block_done_i, 1'b0};

   genvar g;
   generate
      for (g = 0; g < MAX_CH; g = g + 1) begin : g_ch
         if (g < NUM_CH) begin : g_used
            logic en_q;
            logic aed_q;
            logic chn_q;
            logic chns_q;
            logic aen_q;
            logic edet_q;
            logic busy_q;
            logic start_q;
            logic abort_q;
            logic [PRI_W-1:0] pri_q;
            logic wr;
            logic [DATA_W-1:0] wm;
            logic ev_ok;
            logic start_reg;
            logic abort_reg;
            logic chain_hit;
            logic en_d;
            logic edet_d;
            logic busy_d;
            logic done_lower_nb;
            logic done_higher_nb;
            logic wr_en_s;
            logic wr_aed_s;
            logic wr_chn_s;
            logic wr_chns_s;
            logic wr_aen_s;
            logic wr_pri_s;

            assign wr = reg_bus.wr_stb & ctrl_hit & (ch_idx == 3'(g));
            assign wm = CTRL_WMASK & be_mask;
            // one write strobe per field; byte lanes are already folded into wm
            assign wr_en_s = wr & wm[EN_BIT];
            assign wr_aed_s = wr & wm[AED_BIT];
            assign wr_chn_s = wr & wm[CHN_BIT];
            assign wr_chns_s = wr & wm[CHNS_BIT];
            assign wr_aen_s = wr & wm[AEN_BIT];
            assign wr_pri_s = wr & wm[PRI_LSB];

            // events count while enabled, or while disabled if allowed
            assign ev_ok = en_q | aed_q; // [RULE_05]
            assign start_reg = start_event_i[g] & ev_ok; // [RULE_05]
            assign abort_reg = abort_event_i[g] & ev_ok; // [RULE_05]

            // the next lower-priority channel is g+1, the next higher one g-1
            assign done_lower_nb = done_pad[g+2];
            assign done_higher_nb = done_pad[g];
            // the direction select is ignored unless chaining is allowed
            assign chain_hit = chn_q // [RULE_03] [RULE_06]
                               & (chns_q ? done_lower_nb : done_higher_nb); // [RULE_02]

            // enable priority: chaining, then abort, then block end, then software
            always_comb begin
               en_d = en_q;
               if (chain_hit) begin
                  en_d = 1'b1; // [RULE_02]
               end else if (abort_reg) begin
                  en_d = 1'b0;
               end else if (block_done_i[g] && !aen_q) begin
                  en_d = 1'b0; // [RULE_07]
               end else if (wr_en_s) begin
                  en_d = reg_bus.wdata[EN_BIT]; // [RULE_04]
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  en_q <= CTRL_RST[EN_BIT]; // [RULE_12]
               end else begin
                  en_q <= en_d; // [RULE_04]
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  aed_q <= CTRL_RST[AED_BIT]; // [RULE_12]
               end else if (wr_aed_s) begin
                  aed_q <= reg_bus.wdata[AED_BIT]; // [RULE_05]
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  chn_q <= CTRL_RST[CHN_BIT]; // [RULE_12]
               end else if (wr_chn_s) begin
                  chn_q <= reg_bus.wdata[CHN_BIT]; // [RULE_06]
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  chns_q <= CTRL_RST[CHNS_BIT]; // [RULE_12]
               end else if (wr_chns_s) begin
                  chns_q <= reg_bus.wdata[CHNS_BIT]; // [RULE_02]
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  aen_q <= CTRL_RST[AEN_BIT]; // [RULE_12]
               end else if (wr_aen_s) begin
                  aen_q <= reg_bus.wdata[AEN_BIT]; // [RULE_07]
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  pri_q <= CTRL_RST[PRI_LSB +: PRI_W]; // [RULE_12]
               end else if (wr_pri_s) begin
                  pri_q <= reg_bus.wdata[PRI_LSB +: PRI_W]; // [RULE_09]
               end
            end

            // a new event wins over the service clear in the same cycle
            always_comb begin
               edet_d = edet_q;
               if (start_reg || abort_reg) begin
                  edet_d = 1'b1; // [RULE_08] [RULE_13]
               end else if (service_start_i[g]) begin
                  edet_d = 1'b0; // [RULE_13]
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  edet_q <= CTRL_RST[EDET_BIT]; // [RULE_12]
               end else begin
                  edet_q <= edet_d;
               end
            end

            // busy stays up after disable until the open transaction ends
            assign busy_d = en_q | txn_active_i[g]; // [RULE_01] [RULE_10]

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  busy_q <= CTRL_RST[BUSY_BIT]; // [RULE_12]
               end else begin
                  busy_q <= busy_d;
               end
            end

            // request pulses to the datapath, one cycle after the event is taken
            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  start_q <= 1'b0;
               end else begin
                  start_q <= start_reg;
               end
            end

            always_ff @(posedge sys_clk_i) begin
               if (srst_i) begin
                  abort_q <= 1'b0;
               end else begin
                  abort_q <= abort_reg;
               end
            end

            // unimplemented positions are tied to zero
            always_comb begin
               ctrl_rd[g] = '0; // [RULE_11]
               ctrl_rd[g][BUSY_BIT] = busy_q;
               ctrl_rd[g][CHNS_BIT] = chns_q;
               ctrl_rd[g][EN_BIT] = en_q;
               ctrl_rd[g][AED_BIT] = aed_q;
               ctrl_rd[g][CHN_BIT] = chn_q;
               ctrl_rd[g][AEN_BIT] = aen_q;
               ctrl_rd[g][EDET_BIT] = edet_q;
               ctrl_rd[g][PRI_LSB +: PRI_W] = pri_q; // [RULE_09]
            end

            assign done_ev[g] = block_done_i[g];
            assign abort_ev[g] = abort_reg;
            assign ch_enable_o[g] = en_q; // [RULE_04]
            assign ch_busy_o[g] = busy_q;
            assign ch_event_pending_o[g] = edet_q;
            assign start_req_o[g] = start_q;
            assign abort_req_o[g] = abort_q;
            assign ch_priority_o[g*PRI_W +: PRI_W] = pri_q; // [RULE_09]
         end else begin : g_unused
            assign ctrl_rd[g] = '0;
            assign done_ev[g] = 1'b0;
            assign abort_ev[g] = 1'b0;
         end
      end
   endgenerate

   // interrupt status: hardware set wins over a write-one clear
   assign irq_set = {abort_ev, done_ev};
   assign irq_clr = (reg_bus.wr_stb && stat_hit) ?
                    (reg_bus.wdata[IRQ_W-1:0] & be_mask[IRQ_W-1:0]) : '0;
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_stat_q <= IRQ_RST;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // mask writes honour byte lanes so one lane can be changed alone
   always_comb begin
      irq_mask_d = irq_mask_q;
      if (reg_bus.wr_stb && mask_hit) begin
         irq_mask_d = (irq_mask_q & ~be_mask[IRQ_W-1:0])
                      | (reg_bus.wdata[IRQ_W-1:0] & be_mask[IRQ_W-1:0]);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_mask_q <= IRQ_RST;
      end else begin
         irq_mask_q <= irq_mask_d;
      end
   end

   // one level line while any unmasked status bit is set
   assign irq_d = |(irq_stat_q & irq_mask_q);

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_d;
      end
   end

   // status and mask occupy the low half; the upper half reads zero
   assign stat_word = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
   assign mask_word = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};

   // read mux; unmapped addresses read zero
   always_comb begin
      reg_bus.rdata = '0;
      if (ctrl_hit) begin
         reg_bus.rdata = ctrl_rd[ch_idx]; // [RULE_11]
      end else if (stat_hit) begin
         reg_bus.rdata = stat_word;
      end else if (mask_hit) begin
         reg_bus.rdata = mask_word;
      end
   end
endmodule // dcc_dma_ctrl

// file: sim/dcc_chk.sv
`timescale 1ns/1ps
module dcc_chk #(
   parameter int NUM_CH = 4
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // register bus
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [dcc_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // channel side
   input wire logic [NUM_CH-1:0] start_event_i,
   input wire logic [NUM_CH-1:0] abort_event_i,
   input wire logic [NUM_CH-1:0] block_done_i,
   input wire logic [NUM_CH-1:0] txn_active_i,
   input wire logic [NUM_CH-1:0] service_start_i,
   input wire logic [NUM_CH-1:0] ch_enable_o,
   input wire logic [NUM_CH-1:0] ch_busy_o,
   input wire logic [NUM_CH-1:0] ch_event_pending_o,
   input wire logic [NUM_CH-1:0] start_req_o,
   input wire logic [NUM_CH-1:0] abort_req_o,
   input wire logic irq_o
);
   import dcc_pkg::*;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ack;
      !avs_waitrequest_o;
   endsequence
   property p_wait;
      s_req |=> s_ack;
   endproperty
   property p_idle;
      !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
   endproperty
   property p_rd_stands;
      !srst_i && $changed(avs_readdata_o) |-> $past(avs_read_i && avs_waitrequest_o);
   endproperty
   property p_busy;
      !srst_i |-> ch_busy_o == $past(ch_enable_o | txn_active_i);
   endproperty
   property p_start;
      start_event_i[0] && ch_enable_o[0] |=> start_req_o[0] && ch_event_pending_o[0];
   endproperty
   property p_abort;
      abort_event_i[0] && ch_enable_o[0] && !block_done_i[1] |=> abort_req_o[0] && !ch_enable_o[0];
   endproperty
   property p_pend_hold;
      1'b1 |=> ($past(ch_event_pending_o & ~service_start_i) & ~ch_event_pending_o) == '0;
   endproperty
   property p_pend_clr;
      1'b1 |=> (ch_event_pending_o
                & $past(service_start_i & ~(start_event_i | abort_event_i))) == '0;
   endproperty
   property p_rst;
      disable iff (1'b0) srst_i |=> ch_enable_o == '0 && ch_event_pending_o == '0 && !irq_o;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not one cycle");
   a_idle: assert property (p_idle) else $error("wait without request");
   a_rd_stands: assert property (p_rd_stands) else $error("read data moved");
   a_busy: assert property (p_busy) else $error("busy flag wrong");
   a_start: assert property (p_start) else $error("start not registered");
   a_abort: assert property (p_abort) else $error("abort not taken");
   a_pend_hold: assert property (p_pend_hold) else $error("event flag lost");
   a_pend_clr: assert property (p_pend_clr) else $error("event flag kept");
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // dcc_chk

bind dcc_dma_ctrl dcc_chk #(.NUM_CH(NUM_CH)) chk_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .start_event_i(start_event_i),
   .abort_event_i(abort_event_i), .block_done_i(block_done_i), .txn_active_i(txn_active_i),
   .service_start_i(service_start_i), .ch_enable_o(ch_enable_o), .ch_busy_o(ch_busy_o),
   .ch_event_pending_o(ch_event_pending_o), .start_req_o(start_req_o),
   .abort_req_o(abort_req_o), .irq_o(irq_o));

// file: sim/dcc_tb.sv
`timescale 1ns/1ps
module testbench;
   import dcc_pkg::*;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic rd_en = 1'b0, wr_en = 1'b0, wait_o, irq;
   logic [DATA_W-1:0] wdata = '0, rdata, q;
   logic [3:0] st = '0, ab = '0, dn = '0, txn = '0, sv = '0;
   logic [3:0] en_o, busy_o, pend_o, sreq_o, areq_o;
   logic [7:0] pri_o;
   logic [31:0] tbl [4][3] = '{'{32'h120, 32'h4, 32'h1}, '{32'h020, 32'h1, 32'h1},
      '{32'h100, 32'h4, 32'h0}, '{32'h020, 32'h4, 32'h0}};
   int n_errors = 0;
   int check_count = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   dcc_dma_ctrl #(.NUM_CH(4)) dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .start_event_i(st), .abort_event_i(ab), .block_done_i(dn), .txn_active_i(txn),
      .service_start_i(sv), .ch_enable_o(en_o), .ch_busy_o(busy_o),
      .ch_event_pending_o(pend_o), .start_req_o(sreq_o), .abort_req_o(areq_o),
      .ch_priority_o(pri_o), .irq_o(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      rd_en <= ~w;
      wr_en <= w;
      addr <= a;
      wdata <= d;
      do @(posedge sys_clk_i); while (wait_o !== 1'b0);
      q = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, '0);
      chk(q, exp);
   endtask
   // one-cycle pulses on the event inputs, sampled after the outputs settle
   task automatic ev(input logic [3:0] s, input logic [3:0] b, input logic [3:0] d,
                     input logic [3:0] v);
      @(posedge sys_clk_i);
      st <= s;
      ab <= b;
      dn <= d;
      sv <= v;
      @(posedge sys_clk_i);
      st <= '0;
      ab <= '0;
      dn <= '0;
      sv <= '0;
      @(negedge sys_clk_i);
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      n_errors++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(32'(pri_o), 32'h0);
      rdc(8'h00, 32'h0);
      acc(1'b1, 8'h80, 32'hffff_ffff);
      rdc(8'h80, 32'h0);
      acc(1'b1, 8'h00, 32'hffff_ffff);
      rdc(8'h00, 32'h0000_81f3);
      chk(32'(pri_o[1:0]), 32'h3);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 8'h04, 32'(i));
         @(negedge sys_clk_i);
         chk(32'(pri_o[3:2]), 32'(i));
      end
      @(posedge sys_clk_i);
      txn <= 4'h1;
      acc(1'b1, 8'h00, 32'h0);
      rdc(8'h00, 32'h8000);
      chk(32'(en_o[0]), 32'h0);
      txn <= 4'h0;
      rdc(8'h00, 32'h0);
      ev(4'h4, 4'h0, 4'h0, 4'h0);
      chk(32'(pend_o), 32'h0);
      acc(1'b1, 8'h08, 32'h40);
      ev(4'h4, 4'h0, 4'h0, 4'h0);
      chk(32'(sreq_o), 32'h4);
      rdc(8'h08, 32'h44);
      ev(4'h0, 4'h0, 4'h0, 4'h4);
      chk(32'(pend_o), 32'h0);
      acc(1'b1, 8'h0c, 32'h90);
      ev(4'h0, 4'h0, 4'h8, 4'h0);
      chk(32'(en_o[3]), 32'h1);
      acc(1'b1, 8'h0c, 32'h80);
      ev(4'h0, 4'h0, 4'h8, 4'h0);
      chk(32'(en_o[3]), 32'h0);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 8'h04, tbl[i][0]);
         ev(4'h0, 4'h0, tbl[i][1][3:0], 4'h0);
         chk(32'(en_o[1]), tbl[i][2]);
      end
      acc(1'b1, 8'h40, 32'hffff);
      acc(1'b1, 8'h44, 32'h1);
      ev(4'h0, 4'h0, 4'h1, 4'h0);
      @(negedge sys_clk_i);
      chk(32'(irq), 32'h1);
      rdc(8'h40, 32'h1);
      acc(1'b1, 8'h44, 32'h0);
      repeat (2) @(negedge sys_clk_i);
      chk(32'(irq), 32'h0);
      acc(1'b1, 8'h44, 32'h100);
      acc(1'b1, 8'h40, 32'h1);
      rdc(8'h40, 32'h0);
      chk(32'(irq), 32'h0);
      acc(1'b1, 8'h00, 32'h80);
      ev(4'h1, 4'h0, 4'h0, 4'h0);
      chk(32'(sreq_o), 32'h1);
      ev(4'h0, 4'h1, 4'h0, 4'h0);
      chk(32'(areq_o), 32'h1);
      chk(32'(en_o[0]), 32'h0);
      rdc(8'h40, 32'h100);
      chk(32'(irq), 32'h1);
      srst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(32'({en_o, pend_o, irq}), 32'h0);
      wrap_up();
   end
endmodule // testbench
